// ===== hdl/sec_host.sv
// host controller for a 4K x 8 serial nonvolatile memory, SPI mode 0, clock made here
// assumes ser_in comes from the device asynchronously and the register port runs on ref_clk
//
// Overview of operation
// - read sends opcode then 16-bit address
// - read ends by raising select
// - set write latch before every write
// - latch opcode alone, then raise select
// - write frame opcode+address+data, select held
// - raise select only after whole byte
// - status write bits 0,1,4,5,6 zero
// - pause changes only while clock low
// - first select falling edge before command
// - wait 1 ms read, 5 ms write
// - opcode encodings
// - everything shifted MSB first
`timescale 1ns/100ps
`include "sec_regs.svh"

module sec_host
    import sec_pkg::*;
#(
    parameter int PUR_CYC = `SEC_PUR_CYC,
    parameter int PUW_CYC = `SEC_PUW_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output logic ser_clk,
    output logic sel_b,
    output logic ser_out,
    input wire logic ser_in,
    output logic pause_b
);

    logic so_meta;
    logic so_s;
    logic [19:0] pu_cnt;
    logic rd_ok;
    logic wr_ok;
    logic [11:0] addr_reg;
    logic pause_req;
    logic refused;
    logic [7:0] stat_byte;
    logic [7:0] page_buf [0:31];
    sec_phase_t phase;
    sec_step_t step;
    sec_op_t frame_op;
    sec_op_t job_op;
    logic [4:0] job_len;
    logic [15:0] timer;
    logic [2:0] bit_cnt;
    logic [5:0] byte_idx;
    logic [7:0] shreg;
    logic [7:0] rx;

    // two flops on the device data line before anything looks at it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            so_meta <= 1'b0;
            so_s <= 1'b0;
        end else begin
            so_meta <= ser_in;
            so_s <= so_meta;
        end
    end

    // power-up wait counter
    // it stops once writes are allowed, so it never wraps back into the wait
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pu_cnt <= 20'h00000;
        end else if (!wr_ok) begin
            pu_cnt <= pu_cnt + 20'h00001;
        end
    end
    assign rd_ok = (pu_cnt >= 20'(PUR_CYC));
    assign wr_ok = (pu_cnt >= 20'(PUW_CYC));

    // register decode
    wire busy = (phase != PH_IDLE);
    wire in_buf = bus_addr[7] && (bus_addr[1:0] == 2'b00);
    wire cmd_wr = bus_wr && (bus_addr == `SEC_OFS_CMD);
    wire [2:0] req_bits = bus_wdata[`SEC_CMD_OP_LSB +: 3];
    wire req_valid = (req_bits <= 3'(OP_ARRAY_WR));
    wire sec_op_t req_op = sec_op_t'(req_bits);
    wire req_is_wr = (req_op == OP_ARRAY_WR) || (req_op == OP_STATUS_WR);
    // writes wait longer than reads after power-up
    wire req_allowed = req_is_wr ? wr_ok : rd_ok;
    wire cmd_take = cmd_wr && !busy && req_valid && req_allowed;
    wire cmd_refuse = cmd_wr && !cmd_take;

    // frame layout decode
    wire is_array = (frame_op == OP_ARRAY_RD) || (frame_op == OP_ARRAY_WR);
    wire is_latch = (frame_op == OP_SET_LATCH) || (frame_op == OP_CLR_LATCH);
    wire [5:0] hdr_len = is_array ? 6'h03 : 6'h01;
    // write frame: opcode, address, data, select held
    // the length field holds count-1, so a frame never carries more than one page
    wire [5:0] last_idx = is_array ? (6'h03 + {1'b0, job_len}) : (is_latch ? 6'h00 : 6'h01);
    wire [5:0] data_off = byte_idx - hdr_len;
    wire [4:0] data_idx = data_off[4:0];
    wire in_data = (byte_idx >= hdr_len);

    wire [7:0] opcode = (frame_op == OP_SET_LATCH) ? `SEC_OPC_SET_LATCH :
                        (frame_op == OP_CLR_LATCH) ? `SEC_OPC_CLR_LATCH :
                        (frame_op == OP_STATUS_RD) ? `SEC_OPC_STATUS_RD :
                        (frame_op == OP_STATUS_WR) ? `SEC_OPC_STATUS_WR :
                        (frame_op == OP_ARRAY_RD) ? `SEC_OPC_ARRAY_RD : `SEC_OPC_ARRAY_WR;

    // status write byte forced to zero in bits 0,1,4,5,6
    wire [7:0] sr_wr_byte = page_buf[0] & `SEC_SR_WR_MASK;

    // 16-bit address with the upper four bits zero
    wire [7:0] tx_byte = (byte_idx == 6'h00) ? opcode :
                         (is_array && byte_idx == 6'h01) ? {4'h0, addr_reg[11:8]} :
                         (is_array && byte_idx == 6'h02) ? addr_reg[7:0] :
                         (frame_op == OP_STATUS_WR) ? sr_wr_byte : page_buf[data_idx];

    // sample arrives at the bottom, transmit leaves from the top
    wire [7:0] next_rx = {rx[6:0], so_s};
    wire bit_end = (phase == PH_HIGH) && (timer == 16'h0000);
    wire byte_end = bit_end && (bit_cnt == 3'h7);
    wire cap_array = byte_end && in_data && (frame_op == OP_ARRAY_RD);
    // status byte follows the status read opcode
    wire cap_status = byte_end && (byte_idx == 6'h01) && (frame_op == OP_STATUS_RD);
    // address and buffer take no bus writes while a job runs; only array read captures move the buffer during a job
    wire buf_bus_wr = bus_wr && in_buf && !busy;

    // software registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_reg <= `SEC_ADDR_RST;
            pause_req <= 1'b0;
            refused <= 1'b0;
        end else begin
            if (bus_wr && bus_addr == `SEC_OFS_ADDR && !busy) begin
                addr_reg <= bus_wdata[11:0];
            end
            if (bus_wr && bus_addr == `SEC_OFS_PAUSE) begin
                pause_req <= bus_wdata[0];
            end
            // a refusal wins; a take and a refusal cannot fall in one cycle anyway
            if (cmd_refuse) begin
                refused <= 1'b1;
            end else if (cmd_take) begin
                refused <= 1'b0;
            end
        end
    end

    // page buffer: software fills it before a write, array reads land here
    // no reset: contents mean nothing until software or a read fills them
    always_ff @(posedge ref_clk) begin
        if (buf_bus_wr) begin
            page_buf[bus_addr[6:2]] <= bus_wdata[7:0];
        end else if (cap_array) begin
            page_buf[data_idx] <= next_rx;
        end
    end

    // read port, data one cycle after the strobe
    wire [31:0] st_word = {27'h0000000, ~pause_b, refused, wr_ok, rd_ok, busy};
    wire [31:0] rd_mux = (bus_addr == `SEC_OFS_CMD) ? st_word :
                         (bus_addr == `SEC_OFS_ADDR) ? {20'h00000, addr_reg} :
                         (bus_addr == `SEC_OFS_PAUSE) ? {31'h00000000, pause_req} :
                         (bus_addr == `SEC_OFS_SREG) ? {24'h000000, stat_byte} :
                         in_buf ? {24'h000000, page_buf[bus_addr[6:2]]} : 32'h00000000;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata <= 32'h00000000;
        end else begin
            // zero outside the answer cycle, so a late sample cannot pass for fresh data
            bus_rdata <= bus_rd ? rd_mux : 32'h00000000;
        end
    end

    // keep the last status byte read from the device
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_byte <= `SEC_SREG_RST;
        end else if (cap_status) begin
            stat_byte <= next_rx;
        end
    end

    // keep polling while the device reports busy
    wire dev_busy = stat_byte[`SEC_SR_BUSY_BIT];
    wire job_is_wr = (job_op == OP_ARRAY_WR) || (job_op == OP_STATUS_WR);

    // shifter: sampling in the last cycle of the high half gives the device output
    // a full half period after its falling-edge change, sync flops included
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shreg <= 8'h00;
            rx <= 8'h00;
        end else if (phase == PH_LOW && timer == 16'(`SEC_HALF_CYC - 1) && bit_cnt == 3'h0) begin
            // load the byte, MSB goes out first
            shreg <= tx_byte;
        end else if (bit_end) begin
            shreg <= {shreg[6:0], 1'b0};
            rx <= next_rx;
        end
    end
    assign ser_out = shreg[7];

    // frame sequencer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= PH_IDLE;
            step <= STEP_MAIN;
            frame_op <= OP_STATUS_RD;
            job_op <= OP_STATUS_RD;
            job_len <= 5'h00;
            timer <= 16'h0000;
            bit_cnt <= 3'h0;
            byte_idx <= 6'h00;
            ser_clk <= 1'b0;
            // select idles high so the first frame opens with a falling edge
            sel_b <= 1'b1;
            pause_b <= 1'b1;
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (cmd_take) begin
                        job_op <= req_op;
                        job_len <= bus_wdata[`SEC_CMD_LEN_LSB +: 5];
                        // writes open with a latch-only frame
                        step <= req_is_wr ? STEP_LATCH : STEP_MAIN;
                        frame_op <= req_is_wr ? OP_SET_LATCH : req_op;
                        sel_b <= 1'b0;
                        bit_cnt <= 3'h0;
                        byte_idx <= 6'h00;
                        timer <= 16'(`SEC_LEAD_CYC - 1);
                        phase <= PH_LEAD;
                    end
                end
                PH_LEAD: begin
                    // select low a full half period before the first rise
                    if (timer != 16'h0000) begin
                        timer <= timer - 16'h0001;
                    end else begin
                        timer <= 16'(`SEC_HALF_CYC - 1);
                        phase <= PH_LOW;
                    end
                end
                PH_LOW: begin
                    if (timer != 16'h0000) begin
                        timer <= timer - 16'h0001;
                    end else if (pause_req) begin
                        // pause only taken with the clock low
                        pause_b <= 1'b0;
                        phase <= PH_PAUSE;
                    end else begin
                        ser_clk <= 1'b1;
                        timer <= 16'(`SEC_HALF_CYC - 1);
                        phase <= PH_HIGH;
                    end
                end
                PH_PAUSE: begin
                    if (!pause_req) begin
                        // release with the clock still low, a full half period before the edge
                        pause_b <= 1'b1;
                        timer <= 16'(`SEC_HALF_CYC - 1);
                        phase <= PH_LOW;
                    end
                end
                PH_HIGH: begin
                    if (timer != 16'h0000) begin
                        timer <= timer - 16'h0001;
                    end else begin
                        ser_clk <= 1'b0;
                        bit_cnt <= bit_cnt + 3'h1;
                        timer <= 16'(`SEC_HALF_CYC - 1);
                        if (bit_cnt == 3'h7) begin
                            byte_idx <= byte_idx + 6'h01;
                            // frame closes only on a byte boundary
                            phase <= (byte_idx == last_idx) ? PH_LAG : PH_LOW;
                            timer <= (byte_idx == last_idx) ? 16'(`SEC_LAG_CYC - 1) : 16'(`SEC_HALF_CYC - 1);
                        end else begin
                            phase <= PH_LOW;
                        end
                    end
                end
                PH_LAG: begin
                    if (timer != 16'h0000) begin
                        timer <= timer - 16'h0001;
                    end else begin
                        sel_b <= 1'b1;
                        timer <= 16'(`SEC_CS_CYC - 1);
                        phase <= PH_GAP;
                    end
                end
                PH_GAP: begin
                    // select stays high at least the deselect time before the next frame
                    if (timer != 16'h0000) begin
                        timer <= timer - 16'h0001;
                    end else if (step == STEP_LATCH) begin
                        // latch frame already closed, write goes in a fresh frame
                        step <= STEP_MAIN;
                        frame_op <= job_op;
                        sel_b <= 1'b0;
                        bit_cnt <= 3'h0;
                        byte_idx <= 6'h00;
                        timer <= 16'(`SEC_LEAD_CYC - 1);
                        phase <= PH_LEAD;
                    end else if ((step == STEP_MAIN && job_is_wr) || (step == STEP_POLL && dev_busy)) begin
                        // status read frames until the busy flag drops
                        step <= STEP_POLL;
                        frame_op <= OP_STATUS_RD;
                        sel_b <= 1'b0;
                        bit_cnt <= 3'h0;
                        byte_idx <= 6'h00;
                        timer <= 16'(`SEC_LEAD_CYC - 1);
                        phase <= PH_LEAD;
                    end else begin
                        phase <= PH_IDLE;
                    end
                end
                default: begin
                    phase <= PH_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== inc/sec_regs.svh
// register offsets, field positions, opcodes and timing counts of the serial memory host
// assumes a 125 MHz ref_clk and a plain word-aligned register port
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

// controller register map (byte addresses)
`define SEC_OFS_CMD 8'h00
`define SEC_OFS_ADDR 8'h04
`define SEC_OFS_PAUSE 8'h08
`define SEC_OFS_SREG 8'h0C
`define SEC_OFS_BUF 8'h80

// command word fields
`define SEC_CMD_OP_LSB 0
`define SEC_CMD_LEN_LSB 8

// controller state word bits
`define SEC_ST_BUSY 0
`define SEC_ST_RD_OK 1
`define SEC_ST_WR_OK 2
`define SEC_ST_REFUSED 3
`define SEC_ST_PAUSED 4

// reset values
`define SEC_ADDR_RST 12'h000
`define SEC_SREG_RST 8'h00

// device opcodes
`define SEC_OPC_SET_LATCH 8'h06
`define SEC_OPC_CLR_LATCH 8'h04
`define SEC_OPC_STATUS_RD 8'h05
`define SEC_OPC_STATUS_WR 8'h01
`define SEC_OPC_ARRAY_RD 8'h03
`define SEC_OPC_ARRAY_WR 8'h02

// device status byte
`define SEC_SR_BUSY_BIT 0
`define SEC_SR_WR_MASK 8'h8C

// timing
`define SEC_CLK_NS 8
`define SEC_T_HALF_NS 250
`define SEC_T_LEAD_NS 250
`define SEC_T_LAG_NS 250
`define SEC_T_CS_NS 2000
`define SEC_T_PUR_MS 1
`define SEC_T_PUW_MS 5
`define SEC_HALF_CYC ((`SEC_T_HALF_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_LEAD_CYC ((`SEC_T_LEAD_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_LAG_CYC ((`SEC_T_LAG_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_CS_CYC ((`SEC_T_CS_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_PUR_CYC ((`SEC_T_PUR_MS * 1000000 + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_PUW_CYC ((`SEC_T_PUW_MS * 1000000 + `SEC_CLK_NS - 1) / `SEC_CLK_NS)

`endif

// ===== inc/sec_pkg.sv
// types of the serial memory host controller
// constants live in sec_regs.svh
package sec_pkg;

    typedef enum logic [2:0] {
        OP_SET_LATCH, OP_CLR_LATCH, OP_STATUS_RD, OP_STATUS_WR, OP_ARRAY_RD, OP_ARRAY_WR
    } sec_op_t;

    typedef enum logic [2:0] {
        PH_IDLE, PH_LEAD, PH_LOW, PH_HIGH, PH_PAUSE, PH_LAG, PH_GAP
    } sec_phase_t;

    typedef enum logic [1:0] {
        STEP_LATCH, STEP_MAIN, STEP_POLL
    } sec_step_t;

endpackage

// ===== sim/sec_host_props.sv
// pin and frame checker of the serial memory host
// bound to sec_host, sees only its ports
`timescale 1ns/100ps
module sec_host_props #(
    parameter int PUR_CYC = 50,
    parameter int PUW_CYC = 100
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic ser_clk,
    input wire logic sel_b,
    input wire logic ser_out,
    input wire logic ser_in,
    input wire logic pause_b
);
    logic clk_d;
    logic [9:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] op_cur;
    int up_cnt;
    wire ck_rise = ser_clk && !clk_d;
    wire [7:0] sh_nx = {sh[6:0], ser_out};
    // bits are counted per frame, so the count at select rise is the frame length
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_d <= 1'b0;
            bit_cnt <= 10'h000;
            sh <= 8'h00;
            op_cur <= 8'h00;
            up_cnt <= 0;
        end else begin
            clk_d <= ser_clk;
            up_cnt <= (up_cnt < PUW_CYC) ? up_cnt + 1 : up_cnt;
            bit_cnt <= sel_b ? 10'h000 : bit_cnt + 10'(ck_rise);
            sh <= ck_rise ? sh_nx : sh;
            op_cur <= (ck_rise && bit_cnt == 10'h007) ? sh_nx : op_cur;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_end;
        $rose(sel_b);
    endsequence
    a_whole_bytes: assert property (s_end |-> bit_cnt != 10'h000 && bit_cnt[2:0] == 3'h0)
        else $error("frame ends inside a byte");
    a_latch_alone: assert property ((s_end ##0 op_cur == 8'h06) |-> bit_cnt == 10'h008)
        else $error("latch frame not 8 bits");
    a_write_frame: assert property ((s_end ##0 op_cur == 8'h02) |-> bit_cnt >= 10'h020 && up_cnt >= PUW_CYC)
        else $error("short or early write frame");
    a_known_op: assert property (s_end |-> op_cur inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06})
        else $error("unknown opcode sent");
    a_status_data: assert property ((s_end ##0 op_cur == 8'h01) |-> bit_cnt == 10'h010 && (sh & 8'h73) == 8'h00)
        else $error("bad status write byte");
    a_idle_clk_low: assert property (sel_b |-> !ser_clk)
        else $error("clock moves while deselected");
    a_pause_clk_low: assert property ($changed(pause_b) |-> !ser_clk && !$past(ser_clk))
        else $error("pause moved with clock high");
    a_select_lead: assert property ($rose(ser_clk) |-> $past(sel_b, 32) == 1'b0)
        else $error("clock rise without select lead");
    a_read_wait: assert property ($fell(sel_b) |-> up_cnt >= PUR_CYC)
        else $error("frame before power-up wait");
    a_out_stable: assert property (ser_clk |-> $stable(ser_out))
        else $error("data moved while clock high");
endmodule

bind sec_host sec_host_props #(.PUR_CYC(PUR_CYC), .PUW_CYC(PUW_CYC)) i_props (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ser_clk(ser_clk), .sel_b(sel_b), .ser_out(ser_out),
    .ser_in(ser_in), .pause_b(pause_b)
);

// ===== sim/sec_mem_model.sv
// behavioural model of the 4K x 8 serial memory
// assumes mode 0 clocking and commands framed by sel_b
`timescale 1ns/100ps
module sec_mem_model #(
    parameter int WC_NS = 20000
) (
    input wire logic ser_clk,
    input wire logic sel_b,
    input wire logic ser_out,
    input wire logic pause_b,
    output logic ser_in
);
    logic [7:0] mem [4096];
    logic [7:0] pg [32];
    logic [31:0] pm;
    logic [7:0] sr, op, sh, ob;
    logic [11:0] a;
    logic write_latch_flag, write_busy_flag;
    int n;
    initial begin
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
        sr = 8'h00;
        write_latch_flag = 1'b0;
        write_busy_flag = 1'b0;
        n = 0;
        ser_in = 1'b0;
    end
    always @(negedge sel_b) begin
        n = 0;
        pm = '0;
    end
    // msb first, low 12 address bits, edges ignored while paused
    always @(posedge ser_clk) if (!sel_b && pause_b) begin
        sh = {sh[6:0], ser_out};
        n = n + 1;
        if (n == 8) op = sh;
        if (n == 16 || n == 24) a = {a[3:0], sh};
        // status byte, all ones while busy
        if (n % 8 == 0 && op == 8'h05) ob = write_busy_flag ? 8'hFF : {sr[7:2], write_latch_flag, 1'b0};
        // stream and wrap at the top
        if (n % 8 == 0 && n >= 24 && op == 8'h03) begin
            ob = mem[a];
            a = a + 12'h001;
        end
        // page wrap, bytes held until commit
        if (n % 8 == 0 && n >= 32 && op == 8'h02) begin
            pg[a[4:0]] = sh;
            pm[a[4:0]] = 1'b1;
            a[4:0] = a[4:0] + 5'h01;
        end
    end
    always @(negedge ser_clk) if (!sel_b && pause_b && n >= 8) begin
        ser_in = ob[7];
        ob = {ob[6:0], 1'b0};
    end
    // released line inverts; latch and commit only on whole frames
    always @(posedge sel_b) begin
        ser_in = ~ser_in;
        if (n == 8 && op == 8'h06) write_latch_flag = 1'b1;
        if (n == 8 && op == 8'h04) write_latch_flag = 1'b0;
        if (write_latch_flag && !write_busy_flag && n % 8 == 0 && (op == 8'h02 && n >= 32 || op == 8'h01 && n == 16)) begin
            if (op == 8'h01) sr = sh;
            for (int i = 0; i < 32; i++) if (op == 8'h02 && pm[i]) mem[{a[11:5], 5'(i)}] = pg[i];
            write_busy_flag = 1'b1;
        end
    end
    // latch drops when the write completes
    always @(posedge write_busy_flag) begin
        #(WC_NS);
        write_busy_flag = 1'b0;
        write_latch_flag = 1'b0;
    end
endmodule

// ===== sim/sec_host_tb.sv
// self-checking bench of the serial memory host against a memory model
// power-up waits shortened to 50 and 100 cycles
`timescale 1ns/100ps
`include "sec_regs.svh"
module sec_host_tb;
    logic ref_clk, rst_b, bus_wr, bus_rd, rd_d, ser_clk, sel_b, ser_out, ser_in, pause_b;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, seen, s;
    logic [63:0] e;
    logic [63:0] exp_q[$];
    logic [7:0] d [3];
    logic [11:0] wa [3] = '{12'hFFE, 12'hFFF, 12'hFE0};
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    sec_host #(.PUR_CYC(50), .PUW_CYC(100)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ser_clk(ser_clk),
        .sel_b(sel_b), .ser_out(ser_out), .ser_in(ser_in), .pause_b(pause_b));
    sec_mem_model i_mem (.ser_clk(ser_clk), .sel_b(sel_b), .ser_out(ser_out), .pause_b(pause_b), .ser_in(ser_in));
    always #4 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic summarize;
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // a zero mask only captures the word for polling
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        bus_addr <= a;
        bus_rd <= 1'b1;
        exp_q.push_back({m, v});
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic idle;
        do begin
            repeat (40) @(posedge ref_clk);
            rd(`SEC_OFS_CMD, 32'h0, 32'h0);
        end while (seen[0] !== 1'b0);
    endtask
    task automatic job(input logic [31:0] c);
        wr(`SEC_OFS_CMD, c);
        idle();
    endtask
    always @(posedge ref_clk) rd_d <= bus_rd;
    // read data stand only in the cycle after the strobe
    always @(negedge ref_clk) if (rd_d) begin
        e = exp_q.pop_front();
        seen = bus_rdata;
        if (e[63:32] !== 32'h0) chk(seen & e[63:32], e[31:0] & e[63:32]);
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        s = 32'h7F24;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(`SEC_OFS_SREG, 32'h0, 32'hFFFFFFFF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        wr(`SEC_OFS_CMD, 32'h5);
        rd(`SEC_OFS_CMD, 32'h8, 32'hFFFFFFFF);
        repeat (110) @(posedge ref_clk);
        rd(`SEC_OFS_CMD, 32'hE, 32'hFFFFFFFF);
        wr(`SEC_OFS_ADDR, 32'hFFE);
        for (int i = 0; i < 3; i++) begin
            s = lfsr(s);
            d[i] = s[7:0];
            wr(`SEC_OFS_BUF + 8'(4 * i), {24'h0, d[i]});
        end
        job(32'h205);
        for (int i = 0; i < 3; i++) chk({24'h0, i_mem.mem[wa[i]]}, {24'h0, d[i]});
        chk({24'h0, i_mem.mem[12'h000]}, 32'hA5);
        rd(`SEC_OFS_SREG, 32'h0, 32'h3);
        wr(`SEC_OFS_ADDR, 32'hFFE);
        // clear the slots so the read has to land fresh bytes in them
        for (int i = 0; i < 3; i++) wr(`SEC_OFS_BUF + 8'(4 * i), 32'h0);
        wr(`SEC_OFS_CMD, 32'h204);
        repeat (600) @(posedge ref_clk);
        wr(`SEC_OFS_PAUSE, 32'h1);
        repeat (100) @(posedge ref_clk);
        rd(`SEC_OFS_CMD, 32'h11, 32'h11);
        repeat (200) @(posedge ref_clk);
        wr(`SEC_OFS_PAUSE, 32'h0);
        idle();
        for (int i = 0; i < 3; i++) rd(`SEC_OFS_BUF + 8'(4 * i), {24'h0, (i < 2 ? d[i] : 8'hA5)}, 32'hFF);
        job(32'h0);
        job(32'h2);
        rd(`SEC_OFS_SREG, 32'h2, 32'hFF);
        job(32'h1);
        job(32'h2);
        rd(`SEC_OFS_SREG, 32'h0, 32'hFF);
        wr(`SEC_OFS_BUF, 32'hFF);
        job(32'h3);
        job(32'h2);
        rd(`SEC_OFS_SREG, 32'h8C, 32'hFF);
        // an op code past the encodings is refused while idle
        wr(`SEC_OFS_CMD, 32'h6);
        rd(`SEC_OFS_CMD, 32'hE, 32'hF);
        summarize();
    end
endmodule
